/* src/dmea_pkg.sv */
// constants, types and field layouts for the data space decoder and nonvolatile byte port
package dmea_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int PC_W = 14;
	localparam int INSTR_W = 16;
	localparam int DISP_W = 6;
	localparam int REG_AW = 5;
	localparam int IO_AW = 6;
	localparam int SRAM_AW = 11;
	localparam int NV_AW = 10;
	localparam int PLAIN_REGS = 26;
	localparam int SRAM_BYTES = 2048;
	localparam int NV_BYTES = 1024;
	localparam int PTR_NUM = 3;
	localparam int TMR_W = 16;

	// data space map
	localparam logic [ADDR_W-1:0] DS_IO_BASE = 16'h0020;
	localparam logic [ADDR_W-1:0] DS_SRAM_BASE = 16'h0060;
	localparam logic [ADDR_W-1:0] DS_TOP = 16'h0860;
	localparam logic [REG_AW-1:0] PTR_BASE_IDX = 5'h1a;
	localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;

	// nonvolatile port offsets inside the I/O space
	localparam logic [IO_AW-1:0] IO_NV_CTRL = 6'h1c;
	localparam logic [IO_AW-1:0] IO_NV_DATA = 6'h1d;
	localparam logic [IO_AW-1:0] IO_NV_ADDR_LO = 6'h1e;
	localparam logic [IO_AW-1:0] IO_NV_ADDR_HI = 6'h1f;

	// nv_control bit positions
	localparam int CTRL_READ_STROBE = 0;
	localparam int CTRL_WRITE_TRIGGER = 1;
	localparam int CTRL_MASTER_ARM = 2;

	// cycle figures
	localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
	localparam logic [2:0] READ_STALL_CYC = 3'h4;
	localparam logic [2:0] WRITE_STALL_CYC = 3'h2;
	localparam int CLK_HZ = 125000000;
	localparam int NV_OSC_HZ = 1000000;
	localparam int NV_PRESCALE = CLK_HZ / NV_OSC_HZ;
	localparam int NV_WRITE_OSC_CYC = 8448;

	typedef enum logic [2:0] {
		AM_DIRECT = 3'h0,
		AM_IND = 3'h1,
		AM_DISP = 3'h2,
		AM_PREDEC = 3'h3,
		AM_POSTINC = 3'h4
	} dmea_mode_t;

	typedef enum logic [1:0] {
		PTR_X = 2'h0,
		PTR_Y = 2'h1,
		PTR_Z = 2'h2
	} dmea_ptr_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_IO = 2'b01,
		ST_STALL = 2'b11
	} dmea_state_t;

	typedef struct packed {
		logic we;
		dmea_mode_t mode;
		dmea_ptr_t ptr;
		logic [DISP_W-1:0] disp;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dmea_req_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [IO_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dmea_io_t;
endpackage : dmea_pkg

/* src/dmea_byte_ram.sv */
// byte-wide flop storage with one write port and one combinational read port
`timescale 1ns/1ps
module dmea_byte_ram #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [dmea_pkg::DATA_W-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [dmea_pkg::DATA_W-1:0] rdata_o
);
	logic [dmea_pkg::DATA_W-1:0] mem_r [DEPTH];

	// contents have no reset value, as in the real arrays
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem_r[raddr_i];
endmodule : dmea_byte_ram

/* src/dmea_tick.sv */
// wrapping counter that pulses when an enabled count reaches its terminal value
`timescale 1ns/1ps
module dmea_tick #(
	parameter int W = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic [W-1:0] term_i,
	output logic done_o
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	assign done_o = en_i && !clr_i && (cnt_r == term_i);

	always_comb begin
		cnt_nxt = cnt_r;
		if (clr_i) begin
			cnt_nxt = '0;
		end else if (en_i) begin
			cnt_nxt = (cnt_r == term_i) ? '0 : W'(cnt_r + 1'b1);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : dmea_tick

/* src/dmea_top.sv */
// data space decoder, working/pointer registers, sram and nonvolatile byte port
//
// Functional notes
// R1: program fetch uses a 14-bit word address into 16K sixteen-bit words.
// R2: data addresses 0..95 hit registers and I/O, next 2048 hit SRAM.
// R3: registers, I/O and SRAM are reachable through every addressing mode.
// R4: displacement mode adds up to 63 to the Y or Z pointer.
// R5: registers 26..31 are X, Y, Z; pre-decrement and post-increment update them.
// R6: direct addressing reaches every location of the data space.
// R7: each SRAM access completes within two clock cycles.
// R8: separate 1024-byte nonvolatile space with byte read and write.
// R9: nonvolatile address, data and control registers sit in I/O space.
// R10: nonvolatile writes are self-timed and completion is visible to software.
// R11: a nonvolatile read stalls the CPU for four cycles.
// R12: a nonvolatile write start stalls the CPU for two cycles.
// R13: software must use the arm-then-trigger sequence; stray triggers are ignored.
// R14: address register holds 10 bits; upper six bits read zero.
// R15: nonvolatile bytes are addressed linearly from 0 to 1023.
// R16: address register has no reset value; software loads it first.
// R17: a write stores the data register byte at the addressed location.
// R18: a read places the addressed byte into the data register.
// R19: arm opens a four-cycle window; only a trigger inside it starts a write.
// R20: trigger stays set during the write, cleared after 8448 ticks of 1 MHz.
// R21: read strobe completes at once; data register holds result right after.
// R22: during a write, reads are refused and the address cannot change.
`timescale 1ns/1ps
module dmea_top #(
	parameter int WRITE_OSC_CYCLES = dmea_pkg::NV_WRITE_OSC_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [dmea_pkg::PC_W-1:0] pc_i,
	input wire logic [dmea_pkg::INSTR_W-1:0] prog_word_i,
	output logic [dmea_pkg::PC_W-1:0] prog_addr_o,
	output logic [dmea_pkg::INSTR_W-1:0] instr_o,
	input wire logic req_valid_i,
	input wire dmea_pkg::dmea_req_t req_i,
	output logic ack_o,
	output logic [dmea_pkg::DATA_W-1:0] rdata_o,
	output logic stall_o,
	output logic nv_busy_o,
	output dmea_pkg::dmea_io_t io_o,
	input wire logic [dmea_pkg::DATA_W-1:0] io_rdata_i
);
	// program fetch path
	logic [dmea_pkg::PC_W-1:0] prog_addr_r;
	logic [dmea_pkg::INSTR_W-1:0] instr_r;

	// control state
	dmea_pkg::dmea_state_t st_r, st_nxt;
	logic ack_r, ack_nxt;
	logic [dmea_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic stall_r, stall_nxt;
	logic [2:0] stall_cnt_r, stall_cnt_nxt;
	dmea_pkg::dmea_io_t io_r, io_nxt;
	logic arm_r, arm_nxt;
	logic [2:0] arm_cnt_r, arm_cnt_nxt;
	logic busy_r, busy_nxt;

	// nonvolatile port and pointer storage, no reset value
	logic [dmea_pkg::NV_AW-1:0] nv_addr_r, nv_addr_nxt;
	logic [dmea_pkg::DATA_W-1:0] nv_data_r, nv_data_nxt;
	logic [dmea_pkg::NV_AW-1:0] wr_addr_r, wr_addr_nxt;
	logic [dmea_pkg::DATA_W-1:0] wr_data_r, wr_data_nxt;
	logic [dmea_pkg::ADDR_W-1:0] ptr_r [dmea_pkg::PTR_NUM];
	logic [dmea_pkg::ADDR_W-1:0] ptr_nxt [dmea_pkg::PTR_NUM];

	// decode
	logic take;
	logic [1:0] pidx;
	logic [dmea_pkg::ADDR_W-1:0] pval;
	logic [dmea_pkg::ADDR_W-1:0] ea;
	logic is_reg, is_io, is_sram;
	logic [dmea_pkg::REG_AW-1:0] ridx;
	logic is_ptr_byte;
	logic [1:0] rptr;
	logic [dmea_pkg::IO_AW-1:0] io_off;
	logic [dmea_pkg::SRAM_AW-1:0] sidx;
	logic is_nv;
	logic [dmea_pkg::DATA_W-1:0] reg_rd, sram_rd, nv_rd, ptr_rd, nv_reg_rd;
	logic reg_we, sram_we;
	logic wr_ctrl, start_write, start_read;
	logic osc_tick, write_done;

	assign take = req_valid_i && (st_r == dmea_pkg::ST_IDLE);
	assign pidx = (req_i.ptr == dmea_pkg::PTR_Z || req_i.ptr == dmea_pkg::PTR_Y) ? req_i.ptr : 2'h0;
	assign pval = ptr_r[pidx];

	always_comb begin
		case (req_i.mode)
			dmea_pkg::AM_DIRECT: ea = req_i.addr; // R6
			dmea_pkg::AM_IND: ea = pval; // R3
			dmea_pkg::AM_DISP: ea = dmea_pkg::ADDR_W'(pval + {10'h000, req_i.disp}); // R4
			dmea_pkg::AM_PREDEC: ea = dmea_pkg::ADDR_W'(pval - dmea_pkg::PTR_STEP); // R5
			dmea_pkg::AM_POSTINC: ea = pval; // R5
			default: ea = req_i.addr;
		endcase
	end

	// R2
	assign is_reg = ea < dmea_pkg::DS_IO_BASE;
	assign is_io = !is_reg && (ea < dmea_pkg::DS_SRAM_BASE);
	assign is_sram = !is_reg && !is_io && (ea < dmea_pkg::DS_TOP);
	assign ridx = ea[dmea_pkg::REG_AW-1:0];
	assign is_ptr_byte = ridx >= dmea_pkg::PTR_BASE_IDX;
	assign rptr = 2'(5'(ridx - dmea_pkg::PTR_BASE_IDX) >> 1);
	assign io_off = dmea_pkg::IO_AW'(ea - dmea_pkg::DS_IO_BASE);
	assign sidx = dmea_pkg::SRAM_AW'(ea - dmea_pkg::DS_SRAM_BASE);
	// R9
	// only the four port registers stay local; the rest of the I/O space is forwarded
	assign is_nv = is_io && (io_off >= dmea_pkg::IO_NV_CTRL) && (io_off <= dmea_pkg::IO_NV_ADDR_HI);
	assign ptr_rd = ridx[0] ? ptr_r[rptr][15:8] : ptr_r[rptr][7:0];
	assign reg_we = take && req_i.we && is_reg && !is_ptr_byte;
	assign sram_we = take && req_i.we && is_sram; // R7

	assign wr_ctrl = take && req_i.we && is_nv && (io_off == dmea_pkg::IO_NV_CTRL);
	// stray triggers without an open window do nothing
	assign start_write = wr_ctrl && req_i.wdata[dmea_pkg::CTRL_WRITE_TRIGGER] && arm_r && !busy_r; // R13 R19
	assign start_read = wr_ctrl && req_i.wdata[dmea_pkg::CTRL_READ_STROBE] && !busy_r; // R22

	always_comb begin
		case (io_off)
			dmea_pkg::IO_NV_CTRL: nv_reg_rd = {5'h00, arm_r, busy_r, 1'b0}; // R10
			dmea_pkg::IO_NV_DATA: nv_reg_rd = nv_data_r;
			dmea_pkg::IO_NV_ADDR_LO: nv_reg_rd = nv_addr_r[7:0];
			dmea_pkg::IO_NV_ADDR_HI: nv_reg_rd = {6'h00, nv_addr_r[9:8]}; // R14
			default: nv_reg_rd = '0;
		endcase
	end

	dmea_byte_ram #(.DEPTH(dmea_pkg::PLAIN_REGS), .AW(dmea_pkg::REG_AW)) u_regs (
		.clk_sys_i(clk_sys_i),
		.we_i(reg_we),
		.waddr_i(ridx),
		.wdata_i(req_i.wdata),
		.raddr_i(ridx),
		.rdata_o(reg_rd)
	);

	dmea_byte_ram #(.DEPTH(dmea_pkg::SRAM_BYTES), .AW(dmea_pkg::SRAM_AW)) u_sram (
		.clk_sys_i(clk_sys_i),
		.we_i(sram_we),
		.waddr_i(sidx),
		.wdata_i(req_i.wdata),
		.raddr_i(sidx),
		.rdata_o(sram_rd)
	);

	// R8 R15
	dmea_byte_ram #(.DEPTH(dmea_pkg::NV_BYTES), .AW(dmea_pkg::NV_AW)) u_nv (
		.clk_sys_i(clk_sys_i),
		.we_i(write_done),
		.waddr_i(wr_addr_r),
		.wdata_i(wr_data_r),
		.raddr_i(nv_addr_r),
		.rdata_o(nv_rd)
	);

	// 1 MHz enable derived from the system clock, only runs while writing
	dmea_tick #(.W(dmea_pkg::TMR_W)) u_prescale (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.clr_i(start_write),
		.en_i(busy_r),
		.term_i(dmea_pkg::TMR_W'(dmea_pkg::NV_PRESCALE - 1)),
		.done_o(osc_tick)
	);

	dmea_tick #(.W(dmea_pkg::TMR_W)) u_write_time (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.clr_i(start_write),
		.en_i(osc_tick),
		.term_i(dmea_pkg::TMR_W'(WRITE_OSC_CYCLES - 1)),
		.done_o(write_done)
	); // R20

	// pointer pairs: an auto-update wins over a data write to the same pointer byte
	always_comb begin
		for (int i = 0; i < dmea_pkg::PTR_NUM; i++) begin
			ptr_nxt[i] = ptr_r[i];
		end
		if (take && req_i.we && is_reg && is_ptr_byte) begin
			if (ridx[0]) begin
				ptr_nxt[rptr][15:8] = req_i.wdata;
			end else begin
				ptr_nxt[rptr][7:0] = req_i.wdata;
			end
		end
		if (take && req_i.mode == dmea_pkg::AM_PREDEC) begin
			ptr_nxt[pidx] = ea; // R5
		end else if (take && req_i.mode == dmea_pkg::AM_POSTINC) begin
			ptr_nxt[pidx] = dmea_pkg::ADDR_W'(pval + dmea_pkg::PTR_STEP); // R5
		end
	end

	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < dmea_pkg::PTR_NUM; i++) begin
			ptr_r[i] <= ptr_nxt[i];
		end
	end

	// nonvolatile port registers
	always_comb begin
		nv_addr_nxt = nv_addr_r;
		nv_data_nxt = nv_data_r;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		if (take && req_i.we && is_nv && !busy_r) begin
			if (io_off == dmea_pkg::IO_NV_ADDR_LO) begin
				nv_addr_nxt[7:0] = req_i.wdata; // R16 R22
			end else if (io_off == dmea_pkg::IO_NV_ADDR_HI) begin
				nv_addr_nxt[9:8] = req_i.wdata[1:0]; // R14
			end
		end
		if (take && req_i.we && is_nv && io_off == dmea_pkg::IO_NV_DATA) begin
			nv_data_nxt = req_i.wdata;
		end
		if (start_read) begin
			nv_data_nxt = nv_rd; // R18 R21
		end
		if (start_write) begin
			// address and data are latched so a later data write cannot corrupt the byte
			wr_addr_nxt = nv_addr_r; // R17
			wr_data_nxt = nv_data_r; // R17
		end
	end

	always_ff @(posedge clk_sys_i) begin
		nv_addr_r <= nv_addr_nxt;
		nv_data_r <= nv_data_nxt;
		wr_addr_r <= wr_addr_nxt;
		wr_data_r <= wr_data_nxt;
	end

	// access sequencing, stall and write timing
	always_comb begin
		st_nxt = st_r;
		ack_nxt = 1'b0;
		rdata_nxt = rdata_r;
		stall_nxt = stall_r;
		stall_cnt_nxt = stall_cnt_r;
		io_nxt = io_r;
		io_nxt.req = 1'b0;
		arm_nxt = arm_r;
		arm_cnt_nxt = arm_cnt_r;
		busy_nxt = busy_r;
		if (arm_r) begin
			if (arm_cnt_r == 3'h0) begin
				arm_nxt = 1'b0; // R19
			end else begin
				arm_cnt_nxt = 3'(arm_cnt_r - 1'b1);
			end
		end
		if (wr_ctrl && req_i.wdata[dmea_pkg::CTRL_MASTER_ARM]) begin
			arm_nxt = 1'b1; // R19
			arm_cnt_nxt = 3'(dmea_pkg::ARM_WINDOW_CYC - 1'b1);
		end
		if (start_write) begin
			busy_nxt = 1'b1; // R10 R20
		end else if (write_done) begin
			busy_nxt = 1'b0; // R20
		end
		case (st_r)
			dmea_pkg::ST_IDLE: begin
				if (take) begin
					if (is_reg) begin
						rdata_nxt = is_ptr_byte ? ptr_rd : reg_rd; // R3
						ack_nxt = 1'b1;
					end else if (is_sram) begin
						rdata_nxt = sram_rd; // R7
						ack_nxt = 1'b1;
					end else if (is_nv) begin
						rdata_nxt = nv_reg_rd;
						ack_nxt = 1'b1;
					end else if (is_io) begin
						io_nxt.req = 1'b1;
						io_nxt.we = req_i.we;
						io_nxt.addr = io_off;
						io_nxt.wdata = req_i.wdata;
						st_nxt = dmea_pkg::ST_IO;
					end else begin
						// beyond the mapped space: reads give zero, writes are dropped
						rdata_nxt = '0;
						ack_nxt = 1'b1;
					end
					if (start_read) begin
						stall_nxt = 1'b1; // R11
						stall_cnt_nxt = 3'(dmea_pkg::READ_STALL_CYC - 1'b1);
						st_nxt = dmea_pkg::ST_STALL;
					end else if (start_write) begin
						stall_nxt = 1'b1; // R12
						stall_cnt_nxt = 3'(dmea_pkg::WRITE_STALL_CYC - 1'b1);
						st_nxt = dmea_pkg::ST_STALL;
					end
				end
			end
			dmea_pkg::ST_IO: begin
				rdata_nxt = io_rdata_i;
				ack_nxt = 1'b1;
				st_nxt = dmea_pkg::ST_IDLE;
			end
			dmea_pkg::ST_STALL: begin
				if (stall_cnt_r == 3'h0) begin
					stall_nxt = 1'b0; // R11 R12
					st_nxt = dmea_pkg::ST_IDLE;
				end else begin
					stall_cnt_nxt = 3'(stall_cnt_r - 1'b1);
				end
			end
			default: begin
				st_nxt = dmea_pkg::ST_IDLE;
				stall_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= dmea_pkg::ST_IDLE;
			ack_r <= 1'b0;
			rdata_r <= '0;
			stall_r <= 1'b0;
			stall_cnt_r <= 3'h0;
			io_r <= '0;
			arm_r <= 1'b0;
			arm_cnt_r <= 3'h0;
			busy_r <= 1'b0;
			prog_addr_r <= '0;
			instr_r <= '0;
		end else begin
			st_r <= st_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			stall_r <= stall_nxt;
			stall_cnt_r <= stall_cnt_nxt;
			io_r <= io_nxt;
			arm_r <= arm_nxt;
			arm_cnt_r <= arm_cnt_nxt;
			busy_r <= busy_nxt;
			prog_addr_r <= pc_i; // R1
			instr_r <= prog_word_i; // R1
		end
	end

	assign prog_addr_o = prog_addr_r;
	assign instr_o = instr_r;
	assign ack_o = ack_r;
	assign rdata_o = rdata_r;
	assign stall_o = stall_r;
	assign nv_busy_o = busy_r;
	assign io_o = io_r;
endmodule : dmea_top

/* dv/dmea_sva.sv */
// port assertions for the data space decoder and nonvolatile byte port
`timescale 1ns/1ps
module dmea_sva #(
	parameter int WRITE_OSC_CYCLES = 8448
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire dmea_pkg::dmea_req_t req_i,
	input wire logic ack_o,
	input wire logic [dmea_pkg::DATA_W-1:0] rdata_o,
	input wire logic stall_o,
	input wire logic nv_busy_o,
	input wire dmea_pkg::dmea_io_t io_o,
	input wire logic [dmea_pkg::DATA_W-1:0] io_rdata_i
);
	localparam int LIM = WRITE_OSC_CYCLES * 125;
	logic taken, nvw, rd_c, trig_c, armed, start_c;
	logic [5:0] ioa;
	logic [2:0] age_r;
	logic [20:0] bcnt_r;
	// only direct accesses are tracked, so pointer modes never match by accident
	assign taken = req_valid_i && !stall_o && !io_o.req && req_i.mode == dmea_pkg::AM_DIRECT;
	assign nvw = taken && req_i.we && req_i.addr == 16'h003c;
	assign rd_c = nvw && req_i.wdata[0];
	assign trig_c = nvw && req_i.wdata[1];
	assign armed = age_r != 3'h0 && age_r <= 3'h4;
	assign start_c = trig_c && armed && !nv_busy_o;
	assign ioa = 6'(req_i.addr - 16'h0020);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			age_r <= 3'h0;
			bcnt_r <= 21'h0;
		end else begin
			age_r <= (nvw && req_i.wdata[2]) ? 3'h1 : (age_r == 3'h0 || age_r == 3'h5) ? age_r : age_r + 3'h1;
			bcnt_r <= nv_busy_o ? bcnt_r + 21'h1 : 21'h0;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	sequence s_rd_stall;
		stall_o [*4] ##1 !stall_o;
	endsequence
	sequence s_wr_stall;
		stall_o [*2] ##1 !stall_o;
	endsequence
	AST_READ_STALL: assert property (rd_c && !nv_busy_o |=> s_rd_stall)
		else $error("read stall length wrong");
	AST_READ_REFUSED: assert property (rd_c && nv_busy_o |=> !stall_o)
		else $error("read accepted during write");
	AST_WRITE_STALL: assert property ($rose(nv_busy_o) |-> ack_o ##0 s_wr_stall)
		else $error("write stall length wrong");
	AST_WRITE_START: assert property (start_c |=> $rose(nv_busy_o))
		else $error("armed trigger did not start a write");
	AST_BUSY_CAUSE: assert property ($rose(nv_busy_o) |-> $past(start_c))
		else $error("write started without armed trigger");
	AST_WRITE_TIME: assert property ($fell(nv_busy_o) |-> bcnt_r >= LIM - 1 && bcnt_r <= LIM + 2)
		else $error("write time wrong");
	AST_ADDR_HI: assert property (taken && !req_i.we && req_i.addr == 16'h003f |=> ack_o && rdata_o[7:2] == 6'h00)
		else $error("address high reserved bits not zero");
	AST_SRAM_ACK: assert property (taken && req_i.addr >= 16'h0060 && req_i.addr < 16'h0860 |=> ack_o)
		else $error("sram access late");
	AST_IO_FWD: assert property (taken && (req_i.addr >= 16'h0020 && req_i.addr < 16'h003c ||
		req_i.addr >= 16'h0040 && req_i.addr < 16'h0060) |=>
		io_o.req && io_o.addr == $past(ioa) ##1 ack_o && rdata_o == $past(io_rdata_i))
		else $error("io forward wrong");
	AST_NV_LOCAL: assert property (taken && req_i.addr >= 16'h003c && req_i.addr < 16'h0040 |=> ack_o && !io_o.req)
		else $error("nv register not local");
endmodule : dmea_sva
bind dmea_top dmea_sva #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) dmea_sva_inst (.clk_sys_i, .rst_i, .req_valid_i,
	.req_i, .ack_o, .rdata_o, .stall_o, .nv_busy_o, .io_o, .io_rdata_i);

/* dv/dmea_io_model.sv */
// other I/O registers and the program store beyond the decoder
`timescale 1ns/1ps
module dmea_io_model (
	input wire logic clk_sys_i,
	input wire dmea_pkg::dmea_io_t io_i,
	input wire logic [13:0] prog_addr_i,
	output logic [7:0] io_rdata_o,
	output logic [15:0] prog_word_o
);
	logic [7:0] regs [0:63];
	assign prog_word_o = {prog_addr_i, 2'b01};
	// answer stands only while the request does; otherwise the inverse, so a late sample never matches
	assign io_rdata_o = io_i.req ? regs[io_i.addr] : ~regs[io_i.addr];
	always_ff @(posedge clk_sys_i) begin
		if (io_i.req && io_i.we) begin
			regs[io_i.addr] <= io_i.wdata;
		end
	end
endmodule : dmea_io_model

/* dv/tb_data_memory_eeprom_access.sv */
// self-checking bench for the data space decoder and nonvolatile port
`timescale 1ns/1ps
module tb_data_memory_eeprom_access;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [13:0] pc_i = 14'h0;
	logic req_valid_i = 1'b0;
	dmea_pkg::dmea_req_t req_i = '0;
	logic ack_o, stall_o, nv_busy_o;
	logic [13:0] prog_addr_o;
	logic [15:0] prog_word_i, instr_o;
	logic [7:0] rdata_o, io_rdata_i, rd;
	logic [7:0] mem_m [0:2143];
	logic [7:0] nv_m [0:1023];
	dmea_pkg::dmea_io_t io_o;
	int err_count = 0;
	int n_tests = 0;
	int seed = 32'h660b;
	int run = 0;
	int last = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (stall_o === 1'b1) begin
			run++;
		end else if (run != 0) begin
			last = run;
			run = 0;
		end
	end
	dmea_top #(.WRITE_OSC_CYCLES(4)) dmea_top_inst (.clk_sys_i, .rst_i, .pc_i, .prog_word_i, .prog_addr_o,
		.instr_o, .req_valid_i, .req_i, .ack_o, .rdata_o, .stall_o, .nv_busy_o, .io_o, .io_rdata_i);
	dmea_io_model dmea_io_model_inst (.clk_sys_i, .io_i(io_o), .prog_addr_i(prog_addr_o),
		.io_rdata_o(io_rdata_i), .prog_word_o(prog_word_i));
	function automatic logic [15:0] pw(input logic [13:0] p);
		return {p, 2'b01};
	endfunction : pw
	task automatic finish_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick
	task automatic acc(input logic we, input logic [2:0] md, input logic [1:0] pt, input logic [5:0] dp,
		input logic [15:0] a, input logic [7:0] d);
		int k;
		req_i = dmea_pkg::dmea_req_t'({we, md, pt, dp, a, d});
		req_valid_i = 1'b1;
		tick(1);
		// valid stays up between back-to-back calls; rest and idle drop it
		for (k = 0; k < 3 && ack_o !== 1'b1; k++)
			tick(1);
		chk("ack", ack_o, 16'h1);
		rd = rdata_o;
	endtask : acc
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(1'b1, 3'h0, 2'h0, 6'h0, a, d);
	endtask : wr
	task automatic rdd(input logic [15:0] a, input logic [7:0] e);
		acc(1'b0, 3'h0, 2'h0, 6'h0, a, 8'h0);
		chk("rdata", rd, e);
	endtask : rdd
	task automatic idle();
		int k;
		req_valid_i = 1'b0;
		for (k = 0; k < 8 && stall_o !== 1'b0; k++)
			tick(1);
		tick(1);
	endtask : idle
	task automatic rest(input int n);
		req_valid_i = 1'b0;
		tick(n);
	endtask : rest
	task automatic nvw(input logic [15:0] a, input logic [7:0] d, input int g);
		int k;
		wr(16'h003f, a[15:8]);
		wr(16'h003e, a[7:0]);
		wr(16'h003d, d);
		wr(16'h003c, 8'h04);
		rest(g);
		wr(16'h003c, 8'h02);
		chk("busy", nv_busy_o, 16'(g < 4));
		if (g < 4) begin
			nv_m[a] = d;
			idle();
			chk("wstall", 16'(last), 16'h2);
			wr(16'h003e, ~a[7:0]);
			wr(16'h003c, 8'h01);
			chk("refuse", stall_o, 16'h0);
			rdd(16'h003e, a[7:0]);
			req_valid_i = 1'b0;
			for (k = 0; k < 700 && nv_busy_o !== 1'b0; k++)
				tick(1);
			chk("done", nv_busy_o, 16'h0);
		end
	endtask : nvw
	initial begin
		#(8 * 20000);
		err_count++;
		finish_test();
	end
	initial begin
		int i, a, r, s0;
		logic [7:0] d;
		tick(20);
		rst_i = 1'b0;
		chk("rst", {ack_o, stall_o, nv_busy_o, rdata_o}, 16'h0);
		for (i = 0; i < 2; i++) begin
			pc_i = i ? 14'($random(seed)) : 14'h3fff;
			tick(2);
			chk("fetch", instr_o, pw(pc_i));
			chk("paddr", prog_addr_o, 16'(pc_i));
		end
		s0 = seed;
		for (i = 0; i < 80; i++) begin
			r = $random(seed);
			a = i < 2 ? 16'h0060 + i * 16'h07ff : (r[0] ? r[5:1] % 26 : 16'h0060 + r[15:5]);
			mem_m[a] = r[31:24];
			wr(16'(a), r[31:24]);
		end
		seed = s0;
		for (i = 0; i < 80; i++) begin
			r = $random(seed);
			a = i < 2 ? 16'h0060 + i * 16'h07ff : (r[0] ? r[5:1] % 26 : 16'h0060 + r[15:5]);
			rdd(16'(a), mem_m[a]);
		end
		wr(16'h0860, 8'hff);
		rdd(16'h0860, 8'h00);
		wr(16'h001e, 8'h00);
		wr(16'h001f, 8'h01);
		for (i = 0; i < 3; i++)
			acc(1'b1, dmea_pkg::AM_POSTINC, dmea_pkg::PTR_Z, 6'h0, 16'h0, 8'(8'h30 + i));
		rdd(16'h001e, 8'h03);
		acc(1'b0, dmea_pkg::AM_PREDEC, dmea_pkg::PTR_Z, 6'h0, 16'h0, 8'h0);
		chk("predec", rd, 16'h32);
		rdd(16'h001e, 8'h02);
		wr(16'h013f, 8'hc3);
		wr(16'h001c, 8'h00);
		wr(16'h001d, 8'h01);
		acc(1'b0, dmea_pkg::AM_DISP, dmea_pkg::PTR_Y, 6'h3f, 16'h0, 8'h0);
		chk("disp", rd, 16'hc3);
		wr(16'h001a, 8'h25);
		wr(16'h001b, 8'h00);
		acc(1'b1, dmea_pkg::AM_IND, dmea_pkg::PTR_X, 6'h0, 16'h0, 8'h77);
		acc(1'b0, dmea_pkg::AM_IND, dmea_pkg::PTR_X, 6'h0, 16'h0, 8'h0);
		chk("ind_io", rd, 16'h77);
		rdd(16'h0025, 8'h77);
		wr(16'h0050, 8'h9a);
		rdd(16'h0050, 8'h9a);
		wr(16'h003f, 8'hff);
		rdd(16'h003f, 8'h03);
		nvw(16'h0000, 8'h5c, 4);
		for (i = 0; i < 4; i++)
			nvw(i == 0 ? 16'h0000 : i == 1 ? 16'h03ff : 16'($random(seed) & 16'h03ff), 8'($random(seed)), 3 - i % 2);
		for (i = 0; i < 1024; i += 1023) begin
			wr(16'h003f, 8'(i >> 8));
			wr(16'h003e, 8'(i));
			wr(16'h003c, 8'h01);
			idle();
			chk("rstall", 16'(last), 16'h4);
			rdd(16'h003d, nv_m[i]);
		end
		finish_test();
	end
endmodule : tb_data_memory_eeprom_access
